//--- calerr_pkg.sv
// Purpose: shared constants and types for calibration and error-flag logic
// Assumes: 16-bit concentration words, register access by documented port
// Notes: period counts are in hour ticks, not clock cycles
package calerr_pkg;
  localparam int CONC_W = 16;
  localparam logic [15:0] BASE_REF_RST = 16'h0000;
  localparam int ABC_PERIOD_HRS = 720;
  localparam logic [15:0] ABC_PERIOD_RST = 16'(ABC_PERIOD_HRS);
  localparam logic [15:0] STEP_LIMIT_RST = 16'h0010;
  localparam int ERR_FATAL = 0;
  localparam int ERR_COMM = 1;
  localparam int ERR_CAL = 3;
  localparam logic [15:0] ERR_RST = 16'h0000;

  typedef enum logic [2:0] {
    CALERR_CMD_NONE,
    CALERR_CMD_ZERO,
    CALERR_CMD_TARGET,
    CALERR_CMD_BACKGROUND,
    CALERR_CMD_FORCED
  } calerr_cmd_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [15:0] raw;
  } calerr_meas_t;
endpackage

//--- calerr_top.sv
// Purpose: calibration sequencing, baseline correction and error flags
// Assumes: measurement, front-end and bus-fault events come from same-clock logic
// Notes: offset is signed; corrected = raw - offset
`timescale 1ns/1ns
`default_nettype none

module calerr_top import calerr_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // calibration commands
  input wire logic cmd_valid,
  input wire calerr_cmd_t cmd,
  input wire logic [15:0] cal_target,
  input wire logic [15:0] baseline_reference_value,
  input wire logic baseline_ref_we,
  input wire logic [15:0] abc_period,
  input wire logic abc_period_we,
  input wire logic [15:0] step_limit,
  input wire logic auto_baseline_correction,
  input wire logic hour_tick,
  // measurement path
  input wire calerr_meas_t meas,
  output logic [15:0] corrected,
  output logic corrected_valid,
  // fault events
  input wire logic afe_init_fail,
  input wire logic bad_addr_access,
  input wire logic err_clear,
  // status
  output logic [15:0] error_flags,
  output logic cal_busy,
  output logic [15:0] offset
);
  logic [15:0] offset_r, offset_nxt;
  logic [15:0] ref_r, period_r, hours_r, low_r;
  logic low_valid_r;
  logic [15:0] err_r, err_nxt;
  logic [15:0] corr_r;
  logic corr_v_r;
  calerr_cmd_t pend_r;
  logic cal_fail_set;

  // pending manual calibration waits for the next measurement
  wire logic manual_cmd = cmd_valid && (cmd == CALERR_CMD_ZERO || cmd == CALERR_CMD_TARGET ||
                                        cmd == CALERR_CMD_BACKGROUND);
  wire logic forced_cmd = cmd_valid && cmd == CALERR_CMD_FORCED;
  wire logic forced_ok = forced_cmd && auto_baseline_correction && low_valid_r;
  wire logic meas_take = meas.valid && pend_r != CALERR_CMD_NONE;
  wire logic period_end = auto_baseline_correction && hour_tick && (hours_r + 16'h0001 >= period_r);
  wire logic [15:0] cal_ref = (pend_r == CALERR_CMD_TARGET) ? cal_target :
                              (pend_r == CALERR_CMD_BACKGROUND) ? ref_r : 16'h0000;
  // offset needed so the baseline reads as the reference value
  wire logic [15:0] abc_goal = low_r - ref_r;
  wire logic [15:0] abc_diff = abc_goal - offset_r;
  wire logic abc_neg = abc_diff[15];
  wire logic [15:0] abc_mag = abc_neg ? (16'h0000 - abc_diff) : abc_diff;
  wire logic [15:0] abc_step = (abc_mag > step_limit) ? step_limit : abc_mag;
  wire logic [15:0] abc_next = abc_neg ? (offset_r - abc_step) : (offset_r + abc_step);

  always_comb begin
    offset_nxt = offset_r;
    cal_fail_set = 1'b0;
    if (meas_take) begin
      if (meas.ok) offset_nxt = meas.raw - cal_ref;
      else cal_fail_set = 1'b1;
    end else if (forced_ok) begin
      offset_nxt = abc_goal;
    end else if (period_end && low_valid_r) begin
      offset_nxt = abc_next;
    end
    // forced request with correction disabled is reported as a failed calibration
    if (forced_cmd && !forced_ok) cal_fail_set = 1'b1;
  end

  // set wins over clear so no event is lost
  always_comb begin
    err_nxt = err_clear ? 16'h0000 : err_r;
    if (afe_init_fail) err_nxt[ERR_FATAL] = 1'b1;
    if (bad_addr_access) err_nxt[ERR_COMM] = 1'b1;
    if (cal_fail_set) err_nxt[ERR_CAL] = 1'b1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_r <= CALERR_CMD_NONE;
    end else if (manual_cmd) begin
      pend_r <= cmd;
    end else if (meas.valid) begin
      pend_r <= CALERR_CMD_NONE;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      offset_r <= 16'h0000;
      err_r <= ERR_RST;
    end else begin
      offset_r <= offset_nxt;
      err_r <= err_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_r <= BASE_REF_RST;
      period_r <= ABC_PERIOD_RST;
    end else begin
      if (baseline_ref_we) ref_r <= baseline_reference_value;
      if (abc_period_we) period_r <= abc_period;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hours_r <= 16'h0000;
    end else if (!auto_baseline_correction || period_end) begin
      hours_r <= 16'h0000;
    end else if (hour_tick) begin
      hours_r <= hours_r + 16'h0001;
    end
  end

  // lowest reading kept across periods; a fresh period keeps tracking the minimum
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_r <= 16'hffff;
      low_valid_r <= 1'b0;
    end else if (meas.valid && meas.ok && (!low_valid_r || meas.raw < low_r)) begin
      low_r <= meas.raw;
      low_valid_r <= 1'b1;
    end
  end

  // correction uses the offset as of this cycle, so a new calibration applies next sample
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      corr_r <= 16'h0000;
      corr_v_r <= 1'b0;
    end else begin
      corr_v_r <= meas.valid;
      if (meas.valid) corr_r <= meas.raw - offset_r;
    end
  end

  assign corrected = corr_r;
  assign corrected_valid = corr_v_r;
  assign error_flags = err_r;
  assign cal_busy = pend_r != CALERR_CMD_NONE;
  assign offset = offset_r;

  // error flags
  a_comm_flag_set: assert property (@(posedge clock) disable iff (!resetn)
    bad_addr_access |=> error_flags[ERR_COMM]) else $error("comm flag not set");
  a_fatal_flag_set: assert property (@(posedge clock) disable iff (!resetn)
    afe_init_fail |=> error_flags[ERR_FATAL]) else $error("fatal flag not set");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
    error_flags[ERR_CAL] && !err_clear |=> error_flags[ERR_CAL]) else $error("flag lost");
  a_flags_cleared: assert property (@(posedge clock) disable iff (!resetn)
    err_clear && !afe_init_fail && !bad_addr_access && !cal_fail_set
    |=> error_flags == 16'h0000) else $error("clear did not empty flags");
  a_cal_fail_flag: assert property (@(posedge clock) disable iff (!resetn)
    meas_take && !meas.ok |=> error_flags[ERR_CAL]) else $error("bad sample not flagged");
  // forced correction
  a_forced_gated: assert property (@(posedge clock) disable iff (!resetn)
    forced_cmd && !auto_baseline_correction && !meas_take |=> $stable(offset))
    else $error("forced ran while disabled");
  a_forced_fail: assert property (@(posedge clock) disable iff (!resetn)
    forced_cmd && !auto_baseline_correction |=> error_flags[ERR_CAL])
    else $error("forced refusal not flagged");
  a_forced_goal: assert property (@(posedge clock) disable iff (!resetn)
    forced_ok && !meas_take |=> offset == $past(low_r) - $past(ref_r))
    else $error("forced goal not from stored baseline");
  // manual calibrations
  a_zero_first: assert property (@(posedge clock) disable iff (!resetn)
    pend_r == CALERR_CMD_ZERO && meas.valid && meas.ok |=> offset == $past(meas.raw))
    else $error("zero cal not from first sample");
  a_target_cal: assert property (@(posedge clock) disable iff (!resetn)
    pend_r == CALERR_CMD_TARGET && meas.valid && meas.ok
    |=> offset == $past(meas.raw) - $past(cal_target)) else $error("target cal wrong");
  a_background_ref: assert property (@(posedge clock) disable iff (!resetn)
    pend_r == CALERR_CMD_BACKGROUND && meas.valid && meas.ok
    |=> offset == $past(meas.raw) - $past(ref_r)) else $error("background cal wrong");
  a_busy_on_cmd: assert property (@(posedge clock) disable iff (!resetn)
    manual_cmd |=> cal_busy) else $error("manual cmd not pending");
  a_pend_clear: assert property (@(posedge clock) disable iff (!resetn)
    cal_busy && meas.valid && !manual_cmd |=> !cal_busy) else $error("pending not retired");
  // baseline correction
  a_hours_reset: assert property (@(posedge clock) disable iff (!resetn)
    !auto_baseline_correction |=> hours_r == 16'h0000) else $error("hours kept while off");
  a_low_tracks: assert property (@(posedge clock) disable iff (!resetn)
    meas.valid && meas.ok |=> low_valid_r && low_r <= $past(meas.raw))
    else $error("baseline not lowered");
  a_step_cap: assert property (@(posedge clock) disable iff (!resetn)
    period_end && low_valid_r && !meas_take && !forced_ok && !abc_neg
    |=> (offset - $past(offset)) <= $past(step_limit)) else $error("step exceeded");
  a_step_cap_down: assert property (@(posedge clock) disable iff (!resetn)
    period_end && low_valid_r && !meas_take && !forced_ok && abc_neg
    |=> ($past(offset) - offset) <= $past(step_limit)) else $error("down step exceeded");
  // applied offset
  a_offset_hold: assert property (@(posedge clock) disable iff (!resetn)
    !meas_take && !forced_ok && !period_end |=> $stable(offset)) else $error("offset drifted");
  a_apply_offset: assert property (@(posedge clock) disable iff (!resetn)
    meas.valid |=> corrected == $past(meas.raw) - $past(offset)) else $error("offset unused");

  c_zero_cal: cover property (@(posedge clock) disable iff (!resetn)
    pend_r == CALERR_CMD_ZERO && meas.valid);
  c_target_cal: cover property (@(posedge clock) disable iff (!resetn)
    pend_r == CALERR_CMD_TARGET && meas.valid);
  c_forced_cal: cover property (@(posedge clock) disable iff (!resetn) forced_ok);
  c_period_end: cover property (@(posedge clock) disable iff (!resetn) period_end && low_valid_r);
  c_step_capped: cover property (@(posedge clock) disable iff (!resetn)
    period_end && low_valid_r && abc_mag > step_limit);
endmodule

`default_nettype wire

//--- calerr_host.sv
// Purpose: host model issuing calibration commands and register writes
// Assumes: requests change just after a rising edge, non-blocking
// Notes: a careful host, it clears status before each command
`timescale 1ns/1ns
`default_nettype none
module calerr_host import calerr_pkg::*; (
  // clock
  input wire logic clock,
  // host requests
  output logic cmd_valid,
  output calerr_cmd_t cmd,
  output logic [15:0] cal_target,
  output logic [15:0] ref_val,
  output logic ref_we,
  output logic [15:0] period_val,
  output logic period_we,
  output logic err_clear
);
  initial begin
    cmd_valid = 1'b0;
    cmd = CALERR_CMD_NONE;
    cal_target = 16'h0000;
    ref_val = 16'h0000;
    ref_we = 1'b0;
    period_val = 16'h0000;
    period_we = 1'b0;
    err_clear = 1'b0;
  end
  task automatic clear_flags();
    err_clear <= 1'b1;
    @(posedge clock);
    err_clear <= 1'b0;
  endtask
  task automatic pulse_cmd(input calerr_cmd_t c, input logic [15:0] tgt);
    cal_target <= tgt;
    clear_flags();
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd <= CALERR_CMD_NONE;
  endtask
  task automatic write_ref(input logic [15:0] v);
    ref_val <= v;
    ref_we <= 1'b1;
    @(posedge clock);
    ref_we <= 1'b0;
  endtask
  task automatic write_period(input logic [15:0] v);
    period_val <= v;
    period_we <= 1'b1;
    @(posedge clock);
    period_we <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- calerr_tb_top.sv
// Purpose: self-checking bench for calibration and error flags
// Assumes: inputs change by non-blocking assignment at a rising edge; outputs read an edge later
// Notes: step limit starts wide; forced goals bypass it and land in one step
`timescale 1ns/1ns
`default_nettype none
module calerr_tb_top;
  import calerr_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid, ref_we, err_clear, period_we, corrected_valid, cal_busy;
  calerr_cmd_t cmd;
  logic [15:0] cal_target, ref_val, period_val, corrected, error_flags, offset;
  logic [15:0] step_limit = 16'hffff;
  logic hour_tick = 1'b0;
  logic auto_on = 1'b0;
  logic afe_fail = 1'b0;
  logic bad_addr = 1'b0;
  calerr_meas_t meas = '0;
  int n_errors = 0;
  int total_checks = 0;
  always #2 clock = ~clock;
  calerr_host u_calerr_host (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd),
    .cal_target(cal_target), .ref_val(ref_val), .ref_we(ref_we), .period_val(period_val),
    .period_we(period_we), .err_clear(err_clear));
  calerr_top u_calerr_top (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd(cmd), .cal_target(cal_target), .baseline_reference_value(ref_val),
    .baseline_ref_we(ref_we), .abc_period(period_val), .abc_period_we(period_we),
    .step_limit(step_limit), .auto_baseline_correction(auto_on), .hour_tick(hour_tick),
    .meas(meas), .corrected(corrected), .corrected_valid(corrected_valid),
    .afe_init_fail(afe_fail), .bad_addr_access(bad_addr), .err_clear(err_clear),
    .error_flags(error_flags), .cal_busy(cal_busy), .offset(offset));
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // taken at the first edge; the second edge shows what the first one launched
  task automatic sample(input logic [15:0] raw, input logic ok);
    meas <= '{valid: 1'b1, ok: ok, raw: raw};
    @(posedge clock);
    meas <= '{valid: 1'b0, ok: 1'b0, raw: ~raw};
    @(posedge clock);
  endtask
  task automatic settle();
    @(posedge clock);
  endtask
  // quiet cycle after the pulse so back-to-back calls never retoggle in one step
  task automatic tick_hour();
    hour_tick <= 1'b1;
    @(posedge clock);
    hour_tick <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    settle();
    check16(error_flags, ERR_RST);
    check16(offset, 16'h0000);
    check1(corrected_valid, 1'b0);
    u_calerr_host.pulse_cmd(CALERR_CMD_ZERO, 16'h0000);
    settle();
    check1(cal_busy, 1'b1);
    sample(16'h0040, 1'b1);
    check16(offset, 16'h0040);
    check1(cal_busy, 1'b0);
    sample(16'h0050, 1'b1);
    check16(corrected, 16'h0010);
    check1(corrected_valid, 1'b1);
    u_calerr_host.pulse_cmd(CALERR_CMD_TARGET, 16'h0020);
    sample(16'h0070, 1'b1);
    check16(offset, 16'h0050);
    u_calerr_host.write_ref(16'h0005);
    u_calerr_host.pulse_cmd(CALERR_CMD_BACKGROUND, 16'h0020);
    sample(16'h0030, 1'b1);
    check16(offset, 16'h002b);
    sample(16'h0020, 1'b1);
    check16(corrected, 16'hfff5);
    // forced correction is refused while automatic correction is off
    u_calerr_host.pulse_cmd(CALERR_CMD_FORCED, 16'h0000);
    settle();
    check16(offset, 16'h002b);
    check16(error_flags, 16'h0008);
    check1(corrected_valid, 1'b0);
    auto_on <= 1'b1;
    u_calerr_host.pulse_cmd(CALERR_CMD_FORCED, 16'h0000);
    settle();
    check16(offset, 16'h001b);
    check16(error_flags, 16'h0000);
    u_calerr_host.pulse_cmd(CALERR_CMD_ZERO, 16'h0000);
    sample(16'h0001, 1'b0);
    check16(offset, 16'h001b);
    check16(error_flags, 16'h0008);
    check1(cal_busy, 1'b0);
    afe_fail <= 1'b1;
    bad_addr <= 1'b1;
    settle();
    afe_fail <= 1'b0;
    bad_addr <= 1'b0;
    repeat (3) settle();
    check16(error_flags, 16'h000b);
    // a clear that meets a new event keeps that event
    bad_addr <= 1'b1;
    u_calerr_host.clear_flags();
    bad_addr <= 1'b0;
    settle();
    check16(error_flags, 16'h0002);
    u_calerr_host.clear_flags();
    settle();
    check16(error_flags, 16'h0000);
    // goal 0x20 against offset 0x1b, moved at most two counts per period
    u_calerr_host.write_ref(16'h0000);
    step_limit <= 16'h0002;
    repeat (ABC_PERIOD_HRS - 1) tick_hour();
    check16(offset, 16'h001b);
    tick_hour();
    check16(offset, 16'h001d);
    u_calerr_host.write_period(16'h0002);
    tick_hour();
    check16(offset, 16'h001d);
    tick_hour();
    check16(offset, 16'h001f);
    repeat (2) tick_hour();
    check16(offset, 16'h0020);
    sample(16'h0010, 1'b1);
    check16(corrected, 16'hfff0);
    repeat (2) tick_hour();
    check16(offset, 16'h001e);
    // where no low reading ever comes, the host turns the correction off
    auto_on <= 1'b0;
    repeat (2) tick_hour();
    check16(offset, 16'h001e);
    stop_test();
  end
endmodule
`default_nettype wire
